// ### logic/pief_port_io.sv
// Port two/three latches, output modes and port-one falling-edge flags.
`timescale 1ns/10ps
`include "pief_cfg.svh"
module pief_port_io (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Special-function-register access.
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  input wire pief_pkg::pief_byte_t sfr_addr,
  input wire pief_pkg::pief_byte_t sfr_wdata,
  output pief_pkg::pief_byte_t sfr_rdata,
  // Crossbar claims and peripheral drive for port two.
  input wire pief_pkg::pief_byte_t p2_claim,
  input wire pief_pkg::pief_byte_t p2_periph_out,
  // Port one upper pins, inputs only here.
  input wire logic [3:0] p1_hi_in,
  // Port two pins.
  input wire pief_pkg::pief_byte_t p2_in,
  output pief_pkg::pief_byte_t p2_out,
  output pief_pkg::pief_byte_t p2_oe_n,
  // Port three pins.
  input wire pief_pkg::pief_byte_t p3_in,
  output pief_pkg::pief_byte_t p3_out,
  output pief_pkg::pief_byte_t p3_oe_n
);
  import pief_pkg::*;

  pief_state_t s_reg;
  pief_state_t s_next;

  //----------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------

  // Open-drain lets a one float; push-pull drives it. Zero always drives.
  function automatic pief_byte_t drive_oe_n(input pief_byte_t val,
                                            input pief_byte_t mode);
    drive_oe_n = val & ~mode;
  endfunction

  //----------------------------------------------------------------
  // Next-state logic
  //----------------------------------------------------------------

  // Pins are read through two flops since they are asynchronous to clk.
  always_comb begin
    pief_byte_t p2_val;
    logic [3:0] fall;
    s_next = s_reg;
    p2_val = 8'h00;
    fall = 4'h0;
    s_next.p1_s1 = p1_hi_in;
    s_next.p1_s2 = s_reg.p1_s1;
    s_next.p2_s1 = p2_in;
    s_next.p2_s2 = s_reg.p2_s1;
    s_next.p3_s1 = p3_in;
    s_next.p3_s2 = s_reg.p3_s1;
    s_next.p1_prev = s_reg.p1_s2;
    fall = s_reg.p1_prev & ~s_reg.p1_s2; // see (RULE1)
    if (sfr_wr) begin
      if (sfr_addr == `PIEF_ADDR_P2_DATA) begin
        s_next.p2_latch = sfr_wdata;
      end else if (sfr_addr == `PIEF_ADDR_P3_DATA) begin
        s_next.p3_latch = sfr_wdata;
      end else if (sfr_addr == `PIEF_ADDR_P2_MODE) begin
        s_next.p2_mode = sfr_wdata; // see (RULE8)
      end else if (sfr_addr == `PIEF_ADDR_P3_MODE) begin
        s_next.p3_mode = sfr_wdata; // see (RULE9)
      end else if (sfr_addr == `PIEF_ADDR_P1_FLAGS) begin
        // Only zeros clear; low nibble is dropped. see (RULE2) see (RULE3)
        s_next.flags = s_reg.flags & sfr_wdata[7:`PIEF_FLAG_LSB];
      end
    end
    // Edge set wins over a clear in the same cycle. see (RULE2)
    s_next.flags = s_next.flags | fall;
    // Read data: pins normally, latch for read-modify-write.
    s_next.rdata = 8'h00;
    if (sfr_rd) begin
      if (sfr_addr == `PIEF_ADDR_P2_DATA) begin
        s_next.rdata = sfr_rmw ? s_reg.p2_latch : s_reg.p2_s2; // see (RULE7) see (RULE11)
      end else if (sfr_addr == `PIEF_ADDR_P3_DATA) begin
        s_next.rdata = sfr_rmw ? s_reg.p3_latch : s_reg.p3_s2; // see (RULE7) see (RULE11)
      end else if (sfr_addr == `PIEF_ADDR_P2_MODE) begin
        s_next.rdata = s_reg.p2_mode;
      end else if (sfr_addr == `PIEF_ADDR_P3_MODE) begin
        s_next.rdata = s_reg.p3_mode;
      end else if (sfr_addr == `PIEF_ADDR_P1_FLAGS) begin
        s_next.rdata = {s_reg.flags, 4'h0}; // see (RULE3)
      end
    end
    // Crossbar claims override the latch on port two. see (RULE6) see (RULE10)
    p2_val = (p2_claim & p2_periph_out) | (~p2_claim & s_next.p2_latch);
    s_next.p2_out = 8'h00;
    s_next.p2_oe_n = drive_oe_n(p2_val, s_next.p2_mode); // see (RULE4)
    s_next.p3_out = 8'h00;
    s_next.p3_oe_n = drive_oe_n(s_next.p3_latch, s_next.p3_mode); // see (RULE5)
    // Driven pins carry the value; floating ones park at zero.
    s_next.p2_out = p2_val & ~s_next.p2_oe_n;
    s_next.p3_out = s_next.p3_latch & ~s_next.p3_oe_n;
  end

  //----------------------------------------------------------------
  // State register
  //----------------------------------------------------------------

  // Reset leaves ports high in open-drain, so every pin floats.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.p2_latch <= `PIEF_RST_DATA;
      s_reg.p3_latch <= `PIEF_RST_DATA;
      s_reg.p2_mode <= `PIEF_RST_MODE;
      s_reg.p3_mode <= `PIEF_RST_MODE;
      s_reg.flags <= 4'h0;
      s_reg.p1_prev <= 4'hf;
      s_reg.p1_s1 <= 4'hf;
      s_reg.p1_s2 <= 4'hf;
      s_reg.p2_oe_n <= 8'hff;
      s_reg.p3_oe_n <= 8'hff;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sfr_rdata = s_reg.rdata;
  assign p2_out = s_reg.p2_out;
  assign p2_oe_n = s_reg.p2_oe_n;
  assign p3_out = s_reg.p3_out;
  assign p3_oe_n = s_reg.p3_oe_n;

  //----------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_edge_sets_flag: assert property ( // see (RULE1)
    (s_reg.p1_prev[0] && !s_reg.p1_s2[0]) |=> s_reg.flags[0])
    else $error("Falling edge did not set flag.");
  chk_flag_sticky: assert property ( // see (RULE2)
    (s_reg.flags[3] && !(sfr_wr && sfr_addr == `PIEF_ADDR_P1_FLAGS))
    |=> s_reg.flags[3])
    else $error("Flag cleared without a write.");
  chk_flag_clear: assert property ( // see (RULE2)
    (sfr_wr && sfr_addr == `PIEF_ADDR_P1_FLAGS && !sfr_wdata[5]
     && s_reg.p1_prev[1] == s_reg.p1_s2[1]) |=> !s_reg.flags[1])
    else $error("Zero write did not clear flag.");
  chk_flag_low_zero: assert property ( // see (RULE3)
    (sfr_rd && sfr_addr == `PIEF_ADDR_P1_FLAGS) |=> sfr_rdata[3:0] == 4'h0)
    else $error("Unused flag bits read nonzero.");
  chk_p2_od_float: assert property ( // see (RULE4)
    (sfr_wr && sfr_addr == `PIEF_ADDR_P2_DATA && sfr_wdata[0]
     && !s_reg.p2_mode[0] && !p2_claim[0]) |=> p2_oe_n[0])
    else $error("Open-drain one did not float.");
  chk_p3_pp_high: assert property ( // see (RULE5)
    (sfr_wr && sfr_addr == `PIEF_ADDR_P3_DATA && sfr_wdata[0]
     && s_reg.p3_mode[0]) |=> (!p3_oe_n[0] && p3_out[0]))
    else $error("Push-pull one not driven high.");
  chk_p3_zero_low: assert property ( // see (RULE5)
    (sfr_wr && sfr_addr == `PIEF_ADDR_P3_DATA && !sfr_wdata[1])
    |=> (!p3_oe_n[1] && !p3_out[1]))
    else $error("Zero not driven low.");
  chk_p2_claim: assert property ( // see (RULE6)
    (p2_claim[2] && p2_periph_out[2] && s_reg.p2_mode[2]
     && !(sfr_wr && sfr_addr == `PIEF_ADDR_P2_MODE)) |=> p2_out[2])
    else $error("Claimed pin ignored peripheral.");
  chk_pin_read: assert property ( // see (RULE7)
    (sfr_rd && !sfr_rmw && sfr_addr == `PIEF_ADDR_P3_DATA)
    |=> sfr_rdata == $past(s_reg.p3_s2))
    else $error("Pin read did not return pins.");
  chk_rmw_latch: assert property ( // see (RULE11)
    (sfr_rd && sfr_rmw && sfr_addr == `PIEF_ADDR_P2_DATA)
    |=> sfr_rdata == $past(s_reg.p2_latch))
    else $error("RMW read did not return latch.");

  // Further pin, flag and read checks; each bit stands for its whole port.
  chk_edge_top_pin: assert property ( // see (RULE1)
    (s_reg.p1_prev[3] && !s_reg.p1_s2[3]) |=> s_reg.flags[3])
    else $error("Falling edge on the top pin did not set its flag.");
  chk_no_false_set: assert property ( // see (RULE1)
    (!s_reg.flags[2] && !(s_reg.p1_prev[2] && !s_reg.p1_s2[2]))
    |=> !s_reg.flags[2])
    else $error("Flag set without a falling edge.");
  chk_p2_zero_low: assert property ( // see (RULE4)
    (sfr_wr && sfr_addr == `PIEF_ADDR_P2_DATA && !sfr_wdata[3]
     && !p2_claim[3]) |=> (!p2_oe_n[3] && !p2_out[3]))
    else $error("Port-two zero not driven low.");
  chk_p2_pp_high: assert property ( // see (RULE8)
    (sfr_wr && sfr_addr == `PIEF_ADDR_P2_DATA && sfr_wdata[4]
     && s_reg.p2_mode[4] && !p2_claim[4]) |=> (!p2_oe_n[4] && p2_out[4]))
    else $error("Port-two push-pull one not driven high.");
  chk_p3_od_float: assert property ( // see (RULE9)
    (sfr_wr && sfr_addr == `PIEF_ADDR_P3_DATA && sfr_wdata[2]
     && !s_reg.p3_mode[2]) |=> (p3_oe_n[2] && !p3_out[2]))
    else $error("Port-three open-drain one did not float.");
  chk_p2_claim_low: assert property ( // see (RULE6)
    (p2_claim[3] && !p2_periph_out[3]) |=> (!p2_oe_n[3] && !p2_out[3]))
    else $error("Claimed pin not driven low by the peripheral.");
  chk_latch_drives: assert property ( // see (RULE10)
    (!p2_claim[5] && !s_reg.p2_latch[5]
     && !(sfr_wr && sfr_addr == `PIEF_ADDR_P2_DATA))
    |=> (!p2_oe_n[5] && !p2_out[5]))
    else $error("Unclaimed pin not driven from its latch.");
  chk_mode_read: assert property ( // see (RULE8)
    (sfr_rd && sfr_addr == `PIEF_ADDR_P2_MODE)
    |=> sfr_rdata == $past(s_reg.p2_mode))
    else $error("Mode read did not return the mode.");
  chk_p3_rmw_latch: assert property ( // see (RULE11)
    (sfr_rd && sfr_rmw && sfr_addr == `PIEF_ADDR_P3_DATA)
    |=> sfr_rdata == $past(s_reg.p3_latch))
    else $error("RMW read did not return the port-three latch.");
  chk_idle_rdata: assert property (
    !sfr_rd |=> sfr_rdata == 8'h00)
    else $error("Read data not zero outside a read.");

  // Main scenarios that the bench is expected to reach.

  cov_edge_flag: cover property (!s_reg.flags[2] ##1 s_reg.flags[2]);
  cov_flag_clear: cover property (s_reg.flags[0] ##1 !s_reg.flags[0]);
  cov_pp_drive: cover property (!p2_oe_n[7] && p2_out[7]);
  cov_claimed: cover property (p2_claim != 8'h00);
  cov_set_vs_clear: cover property (
    sfr_wr && sfr_addr == `PIEF_ADDR_P1_FLAGS && s_reg.p1_prev[0]
    && !s_reg.p1_s2[0]);
endmodule

// ### inc/pief_cfg.svh
// Constants for the port latch, output-mode and edge-flag register block.
// Functional notes
// (RULE1) Falling edge on port-one pins 7..4 sets the matching pending flag.
// (RULE2) A pending flag holds until software writes zero; new edges keep it set.
// (RULE3) Edge flag bits 3..0 always read zero; writes to them do nothing.
// (RULE4) Port-two latch one drives high in push-pull, else floats; zero drives low.
// (RULE5) Port-three latch one drives high in push-pull, else floats; zero drives low.
// (RULE6) Port-two latch reaches pins only where the crossbar leaves them unclaimed.
// (RULE7) Reading a port data register returns the pin levels, regardless of routing.
// (RULE8) Port-two mode bit: zero open-drain, one push-pull.
// (RULE9) Port-three mode bit: zero open-drain, one push-pull.
// (RULE10) Pins not claimed by a peripheral are driven from their own latch bit.
// (RULE11) Read-modify-write accesses read the latch, not the pins.
`ifndef PIEF_CFG_SVH
`define PIEF_CFG_SVH
`define PIEF_ADDR_P2_DATA 8'ha0
`define PIEF_ADDR_P2_MODE 8'ha6
`define PIEF_ADDR_P3_MODE 8'ha7
`define PIEF_ADDR_P1_FLAGS 8'had
`define PIEF_ADDR_P3_DATA 8'hb0
`define PIEF_RST_DATA 8'hff
`define PIEF_RST_MODE 8'h00
`define PIEF_RST_FLAGS 8'h00
`define PIEF_FLAG_MASK 8'hf0
`define PIEF_FLAG_LSB 4
`endif

// ### inc/pief_pkg.sv
// Types shared by the port I/O edge-flag block.
package pief_pkg;
  typedef logic [7:0] pief_byte_t;
  typedef struct packed {
    logic [7:0] p2_latch;
    logic [7:0] p3_latch;
    logic [7:0] p2_mode;
    logic [7:0] p3_mode;
    logic [3:0] flags;
    logic [3:0] p1_prev;
    logic [3:0] p1_s1;
    logic [3:0] p1_s2;
    logic [7:0] p2_s1;
    logic [7:0] p2_s2;
    logic [7:0] p3_s1;
    logic [7:0] p3_s2;
    logic [7:0] rdata;
    logic [7:0] p2_out;
    logic [7:0] p2_oe_n;
    logic [7:0] p3_out;
    logic [7:0] p3_oe_n;
  } pief_state_t;
endpackage

// ### tb/pief_pin_model.sv
// External circuitry model that resolves the levels of one byte-wide port.
`timescale 1ns/10ps
module pief_pin_model (
  // Drive from the device.
  input wire logic [7:0] dev_out,
  input wire logic [7:0] dev_oe_n,
  // External drive, applied where ext_en is set.
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  // Resolved pin levels.
  output logic [7:0] pin
);
  // A released pin rests at the pull-up, never at its last driven value.
  // The device wins where it drives, so a fight never goes unknown here.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!dev_oe_n[i]) pin[i] = dev_out[i];
      else if (ext_en[i]) pin[i] = ext_val[i];
      else pin[i] = 1'b1;
    end
  end
endmodule

// ### tb/port_io_edge_flags_tb.sv
// Self-checking testbench for the port latch and edge-flag block.
`timescale 1ns/10ps
module port_io_edge_flags_tb;
  import pief_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rmw = 1'b0;
  logic [3:0] p1 = 4'hf;
  pief_byte_t addr = 8'h00, wdata = 8'h00, claim = 8'h00, pout = 8'h00;
  pief_byte_t x2en = 8'h00, x2v = 8'h00, rdata, p2i, p2o, p2e, p3i, p3o, p3e;
  int err_total = 0, total_checks = 0;
  // Clock of 8 ns period.
  always #4 clk = ~clk;
  pief_port_io u_dut (.clk(clk), .rst_n(rst_n), .sfr_wr(wr), .sfr_rd(rd),
    .sfr_rmw(rmw), .sfr_addr(addr), .sfr_wdata(wdata), .sfr_rdata(rdata),
    .p2_claim(claim), .p2_periph_out(pout), .p1_hi_in(p1), .p2_in(p2i),
    .p2_out(p2o), .p2_oe_n(p2e), .p3_in(p3i), .p3_out(p3o), .p3_oe_n(p3e));
  pief_pin_model u_p2 (.dev_out(p2o), .dev_oe_n(p2e), .ext_en(x2en),
    .ext_val(x2v), .pin(p2i));
  pief_pin_model u_p3 (.dev_out(p3o), .dev_oe_n(p3e), .ext_en(8'h00),
    .ext_val(8'h00), .pin(p3i));
  task automatic chk(string what, pief_byte_t exp, pief_byte_t got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Write strobe is held for one rising edge only.
  task automatic wr_reg(pief_byte_t a, pief_byte_t d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // Read data stands in the cycle after the strobe, so sample it there.
  task automatic rd_chk(pief_byte_t a, logic m, pief_byte_t e, string w);
    @(negedge clk);
    rd = 1'b1;
    rmw = m;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    rmw = 1'b0;
    chk(w, e, rdata);
  endtask
  // Pins pass two synchroniser flops and an edge stage before use.
  task automatic settle();
    repeat (5) @(negedge clk);
  endtask
  task automatic t_reset();
    chk("p2_oe_n", 8'hff, p2e);
    chk("p3_oe_n", 8'hff, p3e);
    rd_chk(8'ha6, 1'b0, 8'h00, "p2 mode");
    rd_chk(8'ha7, 1'b0, 8'h00, "p3 mode");
    rd_chk(8'had, 1'b0, 8'h00, "flags");
    rd_chk(8'hb0, 1'b1, 8'hff, "p3 latch");
    rd_chk(8'h55, 1'b0, 8'h00, "unmapped");
    $display("done reset");
  endtask
  task automatic t_drive();
    wr_reg(8'ha0, 8'h5a);
    wr_reg(8'hb0, 8'ha5);
    settle();
    chk("p2 od oe_n", 8'h5a, p2e);
    chk("p3 od oe_n", 8'ha5, p3e);
    chk("p3 od out", 8'h00, p3o);
    wr_reg(8'ha6, 8'hff);
    wr_reg(8'ha7, 8'hff);
    wr_reg(8'hb0, 8'ha5);
    settle();
    chk("p2 pp out", 8'h5a, p2o);
    chk("p3 pp oe_n", 8'h00, p3e);
    chk("p3 pp out", 8'ha5, p3o);
    rd_chk(8'hb0, 1'b0, 8'ha5, "p3 pins");
    $display("done drive");
  endtask
  task automatic t_pins();
    wr_reg(8'ha6, 8'h00);
    wr_reg(8'ha0, 8'hff);
    x2en = 8'h81;
    x2v = 8'h01;
    settle();
    rd_chk(8'ha0, 1'b0, 8'h7f, "p2 pins");
    rd_chk(8'ha0, 1'b1, 8'hff, "p2 latch");
    x2en = 8'h00;
    wr_reg(8'ha6, 8'hff);
    wr_reg(8'ha0, 8'hf0);
    claim = 8'h0f;
    pout = 8'h07;
    settle();
    chk("claimed out", 8'hf7, p2o);
    chk("claimed oe_n", 8'h00, p2e);
    rd_chk(8'ha0, 1'b0, 8'hf7, "claimed pins");
    rd_chk(8'ha0, 1'b1, 8'hf0, "claimed latch");
    claim = 8'h00;
    $display("done pins");
  endtask
  task automatic t_flags();
    p1 = 4'h0;
    settle();
    rd_chk(8'had, 1'b0, 8'hf0, "all edges");
    wr_reg(8'had, 8'h0f);
    rd_chk(8'had, 1'b0, 8'h00, "cleared");
    p1 = 4'hf;
    settle();
    p1 = 4'hd;
    settle();
    rd_chk(8'had, 1'b0, 8'h20, "pin5 edge");
    p1 = 4'hf;
    settle();
    p1 = 4'h0;
    settle();
    rd_chk(8'had, 1'b0, 8'hf0, "edge while set");
    wr_reg(8'had, 8'h70);
    rd_chk(8'had, 1'b0, 8'h70, "clear bit7");
    // An edge that reaches the flag in the cycle of a clear must win.
    wr_reg(8'had, 8'h00);
    p1 = 4'hf;
    settle();
    p1 = 4'he;
    @(negedge clk);
    wr_reg(8'had, 8'h00);
    rd_chk(8'had, 1'b0, 8'h10, "set beats clear");
    $display("done flags");
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Whole run needs under 2000 cycles; the watchdog allows ten times that.
  initial begin
    #160000;
    err_total++;
    test_done();
  end
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_drive();
    t_pins();
    t_flags();
    test_done();
  end
endmodule
